// file: spe_pkg.sv
// How it works
// - In program mode data moves serially; data pin two-way, clock pin is input.
// - Low-voltage entry accepted only while the low-voltage enable bit is one.
// - Enable bit may be cleared only in a high-voltage-entered session.
// - With the enable bit set, master clear reset function is forced on.
package spe_pkg;
  // ****************
  // Constants
  // ****************
  localparam int KEY_BITS = 32;
  // Arbitrary value
  localparam logic [31:0] ENTRY_KEY = 32'h5A3C_96E1;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] KEY_BITS_C = 6'h20;
  localparam logic [31:0] SHIFT_RESET = 32'h0000_0000;

  // ****************
  // Types
  // ****************
  typedef enum logic [1:0] {ST_IDLE, ST_KEY, ST_HV, ST_LV} spe_state_t;

  typedef struct packed {
    logic clk;
    logic dat;
    logic hv;
    logic mclr_n;
  } spe_pins_t;

  typedef struct packed {
    logic active;
    logic hv_session;
    logic lvp_clear_ok;
    logic mclr_reset_en;
  } spe_status_t;
endpackage : spe_pkg

// file: spe_entry.sv
`timescale 1ns/1ps
`default_nettype none
module spe_entry (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire spe_pkg::spe_pins_t PINS,
  input wire logic LVP_ENABLE,
  input wire logic MCLR_CFG_EN,
  input wire logic TX_BIT,
  input wire logic TX_OE,
  output logic DAT_OUT,
  output logic DAT_OE,
  output logic RX_BIT,
  output logic RX_STROBE,
  output spe_pkg::spe_status_t STATUS
);
  import spe_pkg::*;

  // ****************
  // Helpers
  // ****************
  // One session decode shared by the data pin and the status outputs
  function automatic logic in_session(spe_state_t s);
    return (s == ST_HV) || (s == ST_LV);
  endfunction : in_session

  // Key window with the newest bit entering at the bottom
  function automatic logic [31:0] shift_in(logic [31:0] sr, logic b);
    return {sr[30:0], b};
  endfunction : shift_in

  // ****************
  // Reset and pin synchronisers
  // ****************
  logic rst_a_reg;
  logic rst_n_reg;
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_a_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_a_reg <= 1'b1;
      rst_n_reg <= rst_a_reg;
    end
  end

  // Two stages per pin: the programmer's edges are unrelated to our clock
  spe_pins_t s1_reg;
  spe_pins_t s2_reg;
  logic clk_d_reg;
  logic hv_d_reg;
  logic lvp_s1_reg;
  logic lvp_reg;
  always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      // Idle pins, master clear high: no false low level after reset
      s1_reg <= 4'h1;
      s2_reg <= 4'h1;
      clk_d_reg <= 1'b0;
      hv_d_reg <= 1'b0;
      lvp_s1_reg <= 1'b0;
      lvp_reg <= 1'b0;
    end else begin
      s1_reg <= PINS;
      s2_reg <= s1_reg;
      clk_d_reg <= s2_reg.clk;
      hv_d_reg <= s2_reg.hv;
      lvp_s1_reg <= LVP_ENABLE;
      lvp_reg <= lvp_s1_reg;
    end
  end

  // Limitation: each link clock phase must span at least three of our cycles
  logic clk_rise;
  logic clk_fall;
  logic hv_rise;
  assign clk_rise = s2_reg.clk & ~clk_d_reg;
  assign clk_fall = ~s2_reg.clk & clk_d_reg;
  assign hv_rise = s2_reg.hv & ~hv_d_reg;

  // ****************
  // Entry state machine
  // ****************
  spe_state_t state_reg, state_next;
  logic [31:0] shift_reg, shift_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic dout_reg, dout_next;
  logic oe_reg, oe_next;
  logic rx_reg, rx_next;
  logic stb_reg, stb_next;
  logic active;

  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      ST_IDLE: begin
        // High-voltage entry on the rise of high voltage only, with clock and data low;
        // a clock that drops later cannot open a session
        if (hv_rise && !s2_reg.clk && !s2_reg.dat) begin
          state_next = ST_HV;
        end else if (lvp_reg && !s2_reg.mclr_n && !s2_reg.hv) begin
          state_next = ST_KEY;
          shift_next = SHIFT_RESET;
          cnt_next = '0;
        end
      end
      ST_KEY: begin
        if (!lvp_reg || s2_reg.mclr_n) begin
          state_next = ST_IDLE;
        end else if (clk_fall) begin
          // Data sampled on falling clock, msb first
          shift_next = shift_in(shift_reg, s2_reg.dat);
          if (cnt_reg == KEY_BITS_C - 6'h01) begin
            cnt_next = '0;
            // Exact match only; a miss re-arms the window
            if (shift_in(shift_reg, s2_reg.dat) == ENTRY_KEY) begin
              state_next = ST_LV;
            end
          end else begin
            cnt_next = cnt_reg + 6'h01;
          end
        end
      end
      ST_HV: begin
        if (!s2_reg.hv) begin
          state_next = ST_IDLE;
        end
      end
      ST_LV: begin
        // Session lasts only while master clear stays low
        if (s2_reg.mclr_n) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  assign active = in_session(state_reg);

  always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= ST_IDLE;
      shift_reg <= SHIFT_RESET;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      cnt_reg <= cnt_next;
    end
  end

  // ****************
  // Data pin
  // ****************
  // Output moves on the rising link edge, half a period before it is taken;
  // no strobe while driving, so our own bit is never counted as received
  always_comb begin
    dout_next = dout_reg;
    oe_next = 1'b0;
    rx_next = rx_reg;
    stb_next = 1'b0;
    // Serial transfer through the two-way data pin
    if (active) begin
      if (clk_fall) begin
        rx_next = s2_reg.dat;
        stb_next = ~TX_OE;
      end
      if (clk_rise) begin
        dout_next = TX_BIT;
      end
      oe_next = TX_OE;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      dout_reg <= 1'b0;
      oe_reg <= 1'b0;
      rx_reg <= 1'b0;
      stb_reg <= 1'b0;
    end else begin
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      rx_reg <= rx_next;
      stb_reg <= stb_next;
    end
  end

  // ****************
  // Outputs
  // ****************
  spe_status_t status_reg, status_next;
  always_comb begin
    status_next = '0;
    status_next.active = in_session(state_next);
    status_next.hv_session = (state_next == ST_HV);
    // Clearing the enable bit only from a high-voltage session
    status_next.lvp_clear_ok = (state_next == ST_HV);
    // Master clear reset forced on while low-voltage entry enabled
    status_next.mclr_reset_en = lvp_reg | MCLR_CFG_EN;
  end

  always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  assign STATUS = status_reg;
  assign DAT_OUT = dout_reg;
  assign DAT_OE = oe_reg;
  assign RX_BIT = rx_reg;
  assign RX_STROBE = stb_reg;
endmodule : spe_entry
`default_nettype wire

// file: spe_entry_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module spe_entry_asserts (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic LVP_ENABLE,
  input wire logic DAT_OE,
  input wire logic RX_STROBE,
  input wire spe_pkg::spe_status_t STATUS
);
  import spe_pkg::*;
  // ***
  // Checks
  // ***
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  sequence s_lv;
    $rose(STATUS.active) ##0 !STATUS.hv_session;
  endsequence
  a_oe_in_session: assert property (DAT_OE |-> STATUS.active || $past(STATUS.active))
    else $error("oe outside session");
  a_strobe_once: assert property (RX_STROBE |=> !RX_STROBE)
    else $error("long strobe");
  a_lv_enabled: assert property (s_lv |-> $past(LVP_ENABLE, 3))
    else $error("lv entry disabled");
  a_clear_hv_only: assert property (STATUS.lvp_clear_ok |-> STATUS.hv_session)
    else $error("clear outside hv");
  a_lv_no_clear: assert property (s_lv |-> !STATUS.lvp_clear_ok)
    else $error("clear in lv");
  a_mclr_forced: assert property (LVP_ENABLE [*8] |-> STATUS.mclr_reset_en)
    else $error("mclr reset off");
endmodule : spe_entry_asserts
bind spe_entry spe_entry_asserts u_chk (.SYS_CLK, .RESET_N, .LVP_ENABLE, .DAT_OE, .RX_STROBE,
  .STATUS);
`default_nettype wire

// file: spe_prog.sv
`timescale 1ns/1ps
`default_nettype none
module spe_prog (
  input wire logic clk,
  output spe_pkg::spe_pins_t pins
);
  import spe_pkg::*;
  // Idle: clock, data and high voltage low, master clear high, clock still
  initial pins = 4'h1;
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt
  task automatic pulse(input logic b);
    pins.dat = b;
    pins.clk = 1'b1;
    wt(4);
    pins.clk = 1'b0;
    wt(4);
  endtask : pulse
  task automatic lv(input logic [31:0] k);
    pins.mclr_n = 1'b0;
    wt(8);
    for (int i = 31; i >= 0; i--) pulse(k[i]);
    pins.dat = ~pins.dat; // Released line, not a stale level
    wt(8);
  endtask : lv
  task automatic hv(input logic c);
    pins.clk = c;
    pins.dat = 1'b0;
    wt(4);
    pins.hv = 1'b1;
    wt(8);
    pins.clk = 1'b0;
  endtask : hv
  task automatic rel();
    pins.hv = 1'b0;
    pins.mclr_n = 1'b1;
  endtask : rel
endmodule : spe_prog
`default_nettype wire

// file: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import spe_pkg::*;
  logic clk, rst_n, low_voltage_prog_enable, cfg, txb, txo;
  logic dout, doe, rxb, rxs;
  spe_pins_t pp, pw;
  spe_status_t st;
  int seed = 85, error_cnt = 0, samples_checked = 0, stb_cnt = 0;
  logic [31:0] k;
  assign pw = {pp.clk, doe ? dout : pp.dat, pp.hv, pp.mclr_n};
  spe_prog prog (.clk(clk), .pins(pp));
  spe_entry uut (.SYS_CLK(clk), .RESET_N(rst_n), .PINS(pw), .LVP_ENABLE(low_voltage_prog_enable),
    .MCLR_CFG_EN(cfg), .TX_BIT(txb), .TX_OE(txo), .DAT_OUT(dout), .DAT_OE(doe),
    .RX_BIT(rxb), .RX_STROBE(rxs), .STATUS(st));
  function automatic logic [3:0] ex(logic a, logic h);
    return {a, h, a & h, low_voltage_prog_enable | cfg};
  endfunction : ex
  task automatic chk(string n, logic [3:0] s, logic [3:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Counted on the falling edge, half a cycle after the launching edge, so a strobe is seen while it stands
  always @(negedge clk) begin
    if (rxs === 1'b1) begin
      stb_cnt++;
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    conclude();
  end
  initial begin
    rst_n = 1'b0;
    low_voltage_prog_enable = 1'b1;
    cfg = 1'b0; // Corner: config off, enable bit alone must force reset on
    txb = 1'b0;
    txo = 1'b0;
    k = ENTRY_KEY ^ ($random(seed) | 32'h1);
    prog.wt(2);
    rst_n = 1'b1;
    prog.wt(8);
    prog.lv(k);
    chk("bad", st, ex(0, 0));
    prog.lv(ENTRY_KEY);
    chk("lv", st, ex(1, 0));
    prog.pulse(k[0]);
    chk("rx", {3'h0, rxb}, {3'h0, k[0]});
    txo = 1'b1;
    txb = k[1];
    prog.pulse(1'b0);
    chk("tx", {2'h0, doe, dout}, {3'h1, k[1]});
    chk("rxtx", {3'h0, rxb}, {3'h0, k[1]});
    txo = 1'b0;
    prog.rel();
    prog.wt(8);
    chk("end", st, ex(0, 0));
    low_voltage_prog_enable = 1'b0;
    cfg = 1'($random(seed));
    prog.wt(8);
    prog.lv(ENTRY_KEY);
    chk("off", st, ex(0, 0));
    prog.rel();
    prog.hv(1'b1);
    prog.wt(8);
    chk("hvclk", st, ex(0, 0));
    prog.rel();
    prog.hv(1'b0);
    prog.wt(8);
    chk("hv", st, ex(1, 1));
    chk("stb", 4'(stb_cnt), 4'h1);
    prog.rel();
    prog.wt(8);
    conclude();
  end
endmodule : tb
`default_nettype wire
